// >>> core/tcc_timer_channel.sv
// One 16-bit timer channel with its registers behind an AXI4-Lite slave.
// Assumes the master keeps AXI4-Lite handshakes and a single clock.
`default_nettype none
module tcc_timer_channel (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [31:0] i_axi_awaddr,
    input wire logic i_axi_awvalid,
    output logic o_axi_awready,
    input wire logic [31:0] i_axi_wdata,
    input wire logic [3:0] i_axi_wstrb,
    input wire logic i_axi_wvalid,
    output logic o_axi_wready,
    output logic [1:0] o_axi_bresp,
    output logic o_axi_bvalid,
    input wire logic i_axi_bready,
    input wire logic [31:0] i_axi_araddr,
    input wire logic i_axi_arvalid,
    output logic o_axi_arready,
    output logic [31:0] o_axi_rdata,
    output logic [1:0] o_axi_rresp,
    output logic o_axi_rvalid,
    input wire logic i_axi_rready,
    output logic o_irq
);
    logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
    logic [29:0] wa_r, wa_nxt;
    logic [31:0] wd_r, wd_nxt, rdata_r, rdata_nxt;
    logic [3:0] ws_r, ws_nxt;
    logic awready_r, awready_nxt, wready_r, wready_nxt;
    logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [7:0] start_r, start_nxt, ien_r, ien_nxt;
    tcc_pkg::tcc_ctrl_type ctrl_r, ctrl_nxt;
    tcc_pkg::tcc_mode_type mode_r, mode_nxt;
    logic [15:0] stop_r, stop_nxt, cnt_r, cnt_nxt;
    logic [15:0] gr_r [4];
    logic [15:0] gr_nxt [4];
    logic [1:0] flags_r, flags_nxt, armed_r, armed_nxt;
    logic [5:0] dv_r, dv_nxt;
    logic phase_r, phase_nxt, irq_r, irq_nxt, clr_hit, wr_cnt;
    logic do_wr, rd_take, stopped, phase, tick, tick_en, match_a, match_b;

    // Register indices that answer OKAY.
    function automatic logic mapped(input logic [29:0] a);
        mapped = (a == tcc_pkg::IDX_START) || (a == tcc_pkg::IDX_CTRL) ||
            (a == tcc_pkg::IDX_MODE) || (a == tcc_pkg::IDX_IEN) ||
            (a == tcc_pkg::IDX_STAT) || (a == tcc_pkg::IDX_CNT) ||
            (a == tcc_pkg::IDX_ICLR) || (a == tcc_pkg::IDX_MSTP) ||
            (a >= tcc_pkg::IDX_GRA && a < tcc_pkg::IDX_GRA + 30'h8 &&
            !a[0]);
    endfunction
    // Merges a 16-bit register with the low two write lanes.
    function automatic logic [15:0] wr16(input logic [15:0] old,
            input logic [31:0] d, input logic [3:0] s);
        wr16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction
    // Picks the divider bit that forms the prescaled clock.
    function automatic logic phase_of(input logic [5:0] dv,
            input logic [2:0] psc);
        case (psc)
            3'h1: phase_of = dv[1];
            3'h2: phase_of = dv[3];
            default: phase_of = dv[5];
        endcase
    endfunction
    // Handshake terms and the tick; every mode code counts normally.
    assign do_wr = aw_have_r && w_have_r && !bvalid_r;
    assign rd_take = arready_r && i_axi_arvalid;
    assign stopped = stop_r[tcc_pkg::STOP_BIT];
    assign phase = phase_of(dv_r, ctrl_r.psc);
    assign tick = (ctrl_r.psc == tcc_pkg::PSC_DIV1) ||
        (ctrl_r.edge_sel == tcc_pkg::EDGE_FALL ? phase_r && !phase :
        ctrl_r.edge_sel == tcc_pkg::EDGE_RISE ? !phase_r && phase :
        phase_r != phase);
    assign tick_en = start_r[tcc_pkg::RUN_BIT] && !stopped && tick;
    assign match_a = tick_en && (cnt_r == gr_r[0]);
    assign match_b = tick_en && (cnt_r == gr_r[1]);
    assign clr_hit = (ctrl_r.clr == tcc_pkg::CLR_B && match_b) ||
        (ctrl_r.clr == tcc_pkg::CLR_A && match_a);
    assign wr_cnt = do_wr && wa_r == tcc_pkg::IDX_CNT && |ws_r[1:0];

    // Bus slave: holds address and data, answers one cycle later.
    always_comb begin
        aw_have_nxt = aw_have_r;
        wa_nxt = wa_r;
        w_have_nxt = w_have_r;
        wd_nxt = wd_r;
        ws_nxt = ws_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (awready_r && i_axi_awvalid) begin
            aw_have_nxt = 1'b1;
            wa_nxt = i_axi_awaddr[31:2];
        end
        if (wready_r && i_axi_wvalid) begin
            w_have_nxt = 1'b1;
            wd_nxt = i_axi_wdata;
            ws_nxt = i_axi_wstrb;
        end
        if (do_wr) begin
            aw_have_nxt = 1'b0;
            w_have_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = mapped(wa_r) ? tcc_pkg::RESP_OKAY :
                tcc_pkg::RESP_SLVERR;
        end else if (bvalid_r && i_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (rd_take) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = mapped(i_axi_araddr[31:2]) ? tcc_pkg::RESP_OKAY :
                tcc_pkg::RESP_SLVERR;
            rdata_nxt = 32'h00000000;
            case (i_axi_araddr[31:2])
                tcc_pkg::IDX_START: rdata_nxt[7:0] = start_r;
                tcc_pkg::IDX_CTRL: rdata_nxt[7:0] = ctrl_r;
                tcc_pkg::IDX_MODE: rdata_nxt[7:0] = mode_r;
                tcc_pkg::IDX_IEN: rdata_nxt[7:0] = ien_r;
                tcc_pkg::IDX_STAT: rdata_nxt[1:0] = flags_r;
                tcc_pkg::IDX_CNT: rdata_nxt[15:0] = cnt_r;
                tcc_pkg::IDX_MSTP: rdata_nxt[15:0] = stop_r;
                default: begin
                    for (int i = 0; i < 4; i++) begin
                        if (i_axi_araddr[31:2] ==
                                tcc_pkg::IDX_GRA + 30'(2 * i)) begin
                            rdata_nxt[15:0] = gr_r[i];
                        end
                    end
                end
            endcase
        end else if (rvalid_r && i_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        awready_nxt = !aw_have_nxt && !bvalid_nxt;
        wready_nxt = !w_have_nxt && !bvalid_nxt;
        arready_nxt = !rvalid_nxt;
    end

    // Registers the bus slave state.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            wa_r <= 30'h00000000;
            wd_r <= 32'h00000000;
            ws_r <= 4'h0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= tcc_pkg::RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rresp_r <= tcc_pkg::RESP_OKAY;
            rdata_r <= 32'h00000000;
        end else begin
            aw_have_r <= aw_have_nxt;
            w_have_r <= w_have_nxt;
            wa_r <= wa_nxt;
            wd_r <= wd_nxt;
            ws_r <= ws_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Timer: counting, buffer transfers, flags, then software writes.
    always_comb begin
        start_nxt = start_r;
        ctrl_nxt = ctrl_r;
        mode_nxt = mode_r;
        ien_nxt = ien_r;
        stop_nxt = stop_r;
        cnt_nxt = cnt_r;
        gr_nxt = gr_r;
        flags_nxt = flags_r;
        armed_nxt = armed_r;
        dv_nxt = stopped ? dv_r : dv_r + 6'h01;
        phase_nxt = phase;
        if (tick_en) begin
            cnt_nxt = clr_hit ? 16'h0000 : cnt_r + 16'h0001;
        end
        if (match_a && mode_r.pair_a) begin
            gr_nxt[0] = gr_r[2];
        end
        if (match_b && mode_r.pair_b) begin
            gr_nxt[1] = gr_r[3];
        end
        if (rd_take && i_axi_araddr[31:2] == tcc_pkg::IDX_STAT) begin
            armed_nxt = armed_r | flags_r;
        end
        if (do_wr && ws_r[0] && !stopped) begin
            if (wa_r == tcc_pkg::IDX_STAT) begin
                flags_nxt = flags_r & ~(armed_r & ~wd_r[1:0]);
            end else if (wa_r == tcc_pkg::IDX_ICLR) begin
                flags_nxt = flags_r & ~(armed_r & wd_r[1:0]);
            end
        end
        flags_nxt = flags_nxt | {match_b, match_a}; // Set wins.
        armed_nxt = armed_nxt & flags_nxt;
        if (do_wr && ws_r[0]) begin
            case (wa_r)
                tcc_pkg::IDX_START: start_nxt = wd_r[7:0];
                tcc_pkg::IDX_CTRL: ctrl_nxt = wd_r[7:0];
                tcc_pkg::IDX_MODE: mode_nxt = wd_r[7:0];
                tcc_pkg::IDX_IEN: ien_nxt = wd_r[7:0];
                default: ;
            endcase
        end
        if (do_wr && wa_r == tcc_pkg::IDX_MSTP) begin
            stop_nxt = wr16(stop_r, wd_r, ws_r);
        end
        if (wr_cnt) begin
            cnt_nxt = wr16(cnt_r, wd_r, ws_r);
        end
        for (int i = 0; i < 4; i++) begin
            if (do_wr && wa_r == tcc_pkg::IDX_GRA + 30'(2 * i)) begin
                gr_nxt[i] = wr16(gr_r[i], wd_r, ws_r);
            end
        end
        irq_nxt = |(flags_r & ien_r[1:0]);
    end

    // Registers the timer state.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            start_r <= tcc_pkg::BYTE_RST;
            ctrl_r <= tcc_pkg::BYTE_RST;
            mode_r <= tcc_pkg::BYTE_RST;
            ien_r <= tcc_pkg::BYTE_RST;
            stop_r <= tcc_pkg::STOP_RST;
            cnt_r <= tcc_pkg::CNT_RST;
            flags_r <= 2'h0;
            armed_r <= 2'h0;
            dv_r <= tcc_pkg::DIV_RST;
            phase_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            start_r <= start_nxt;
            ctrl_r <= ctrl_nxt;
            mode_r <= mode_nxt;
            ien_r <= ien_nxt;
            stop_r <= stop_nxt;
            cnt_r <= cnt_nxt;
            flags_r <= flags_nxt;
            armed_r <= armed_nxt;
            dv_r <= dv_nxt;
            phase_r <= phase_nxt;
            irq_r <= irq_nxt;
        end
    end
    // Registers the four general registers.
    for (genvar g = 0; g < 4; g++) begin : g_gr
        always_ff @(posedge i_mclk or posedge i_rst) begin
            if (i_rst) begin
                gr_r[g] <= tcc_pkg::GR_RST;
            end else begin
                gr_r[g] <= gr_nxt[g];
            end
        end
    end
    // Outputs come straight from flip-flops.
    assign o_axi_awready = awready_r;
    assign o_axi_wready = wready_r;
    assign o_axi_bvalid = bvalid_r;
    assign o_axi_bresp = bresp_r;
    assign o_axi_arready = arready_r;
    assign o_axi_rvalid = rvalid_r;
    assign o_axi_rresp = rresp_r;
    assign o_axi_rdata = rdata_r;
    assign o_irq = irq_r;
    // Checks on the timer behaviour.
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);
    chk_halt_holds: assert property (
        !start_r[tcc_pkg::RUN_BIT] && !wr_cnt |=> $stable(cnt_r))
        else $error("Halted counter moved.");
    chk_run_counts: assert property (
        tick_en && !clr_hit && !wr_cnt |=> cnt_r == $past(cnt_r) + 16'h1)
        else $error("Running counter did not add one.");
    chk_flag_a_set: assert property (
        match_a |=> flags_r[tcc_pkg::FLAG_A])
        else $error("Match flag A not set.");
    chk_flag_clear: assert property (
        $fell(flags_r[tcc_pkg::FLAG_A]) |-> $past(armed_r[0]) && $past(do_wr))
        else $error("Flag A cleared without the read first.");
    chk_clear_on_b: assert property (
        match_b && ctrl_r.clr == tcc_pkg::CLR_B && !wr_cnt |=> cnt_r == 16'h0)
        else $error("Counter not cleared on match B.");
    chk_falling_edge: assert property (
        tick && ctrl_r.psc != tcc_pkg::PSC_DIV1 &&
        ctrl_r.edge_sel == tcc_pkg::EDGE_FALL |-> $past(phase) && !phase)
        else $error("Tick not on a falling edge.");
    chk_undivided: assert property (
        (start_r[0] && !stopped && !wr_cnt && !clr_hit &&
        ctrl_r.psc == tcc_pkg::PSC_DIV1)[*3] |->
        cnt_r == $past(cnt_r, 2) + 16'h2)
        else $error("Undivided clock did not count each cycle.");
    chk_single_b: assert property (
        match_b && !mode_r.pair_b &&
        !(do_wr && wa_r == tcc_pkg::IDX_GRA + 30'h2) |=> $stable(gr_r[1]))
        else $error("Unpaired register B changed on match.");
    chk_pair_a: assert property (
        match_a && mode_r.pair_a && !(do_wr && wa_r == tcc_pkg::IDX_GRA)
        |=> gr_r[0] == $past(gr_r[2]))
        else $error("Buffer C not moved into A.");
    chk_stop_freeze: assert property (
        stopped && !wr_cnt |=> $stable(cnt_r) && $stable(flags_r))
        else $error("Stopped channel changed.");
    chk_irq_level: assert property (
        flags_r[0] && ien_r[0] |=> o_irq)
        else $error("Interrupt not raised.");
endmodule
`default_nettype wire

// >>> core/tcc_pkg.sv
// Constants and carrier types for the timer channel core.
// Assumes a 32-bit AXI4-Lite master and one clock domain.
`default_nettype none
package tcc_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [29:0] IDX_START = 30'h0fffb00;
    localparam logic [29:0] IDX_CTRL = 30'h0fffb10;
    localparam logic [29:0] IDX_MODE = 30'h0fffb11;
    localparam logic [29:0] IDX_IEN = 30'h0fffb14;
    localparam logic [29:0] IDX_STAT = 30'h0fffb15;
    localparam logic [29:0] IDX_CNT = 30'h0fffb16;
    localparam logic [29:0] IDX_GRA = 30'h0fffb18;
    localparam logic [29:0] IDX_ICLR = 30'h0fffb20;
    localparam logic [29:0] IDX_MSTP = 30'h0fffdc8;
    // Bit positions.
    localparam int RUN_BIT = 0;
    localparam int FLAG_A = 0;
    localparam int FLAG_B = 1;
    localparam int STOP_BIT = 1;
    // Field codes.
    localparam logic [2:0] CLR_A = 3'h1;
    localparam logic [2:0] CLR_B = 3'h2;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [2:0] PSC_DIV1 = 3'h0;
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    // Values after reset.
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] STOP_RST = 16'h0000;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] GR_RST = 16'hffff;
    localparam logic [5:0] DIV_RST = 6'h00;
    // Bus answers.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef struct packed {
        logic [2:0] clr;
        logic [1:0] edge_sel;
        logic [2:0] psc;
    } tcc_ctrl_type;
    typedef struct packed {
        logic [1:0] rsv;
        logic pair_b;
        logic pair_a;
        logic [3:0] mode;
    } tcc_mode_type;
endpackage
`default_nettype wire

// >>> tb/tcc_timer_channel_bench.sv
// Self-checking bench for the timer channel core over its AXI4-Lite port.
// Assumes the core and its package are compiled first; one 200 MHz clock.
`default_nettype none
module tcc_timer_channel_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [29:0] IDX_GRB = 30'h0fffb1a;
    localparam logic [29:0] IDX_GRC = 30'h0fffb1c;
    localparam logic [29:0] IDX_GRD = 30'h0fffb1e;
    localparam logic [29:0] IDX_VOID = 30'h0fffb30;
    localparam logic [1:0] OK = tcc_pkg::RESP_OKAY;
    logic mclk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq;
    logic [31:0] awaddr, wdata, araddr, rdata, a, b;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int err_count = 0;
    int checks_done = 0;
    int cyc = 0;
    int ta, tb;
    tcc_timer_channel dut (.i_mclk(mclk), .i_rst(rst), .i_axi_awaddr(awaddr),
        .i_axi_awvalid(awvalid), .o_axi_awready(awready), .i_axi_wdata(wdata),
        .i_axi_wstrb(wstrb), .i_axi_wvalid(wvalid), .o_axi_wready(wready),
        .o_axi_bresp(bresp), .o_axi_bvalid(bvalid), .i_axi_bready(bready),
        .i_axi_araddr(araddr), .i_axi_arvalid(arvalid),
        .o_axi_arready(arready), .o_axi_rdata(rdata), .o_axi_rresp(rresp),
        .o_axi_rvalid(rvalid), .i_axi_rready(rready), .o_irq(irq));
    // Free-running clock and a cycle count used to time register reads.
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("comparisons %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Compares a value with its expectation and counts the outcome.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string msg);
        checks_done++;
        if (got !== exp) begin
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got,
                exp);
            err_count++;
        end
    endtask
    // One AXI4-Lite write; address and data are offered together.
    task automatic wr(input logic [29:0] idx, input logic [31:0] d,
        input logic [3:0] s, input logic [1:0] er);
        @(posedge mclk);
        awaddr <= {idx, 2'b00};
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er}, "write response");
    endtask
    // One AXI4-Lite read; tk is the cycle at which the address was taken.
    task automatic rd(input logic [29:0] idx, output logic [31:0] q,
        input logic [1:0] er, output int tk);
        tk = 0;
        @(posedge mclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                tk = cyc;
            end
        end while (rvalid !== 1'b1);
        q = rdata;
        rready <= 1'b0;
        chk({30'h0, rresp}, {30'h0, er}, "read response");
    endtask
    task automatic rdchk(input logic [29:0] idx, input logic [31:0] exp,
        input string msg);
        logic [31:0] q;
        int tk;
        rd(idx, q, OK, tk);
        chk(q, exp, msg);
    endtask
    // Reset values and the unmapped address.
    task automatic t_reset();
        logic [31:0] q;
        int tk;
        rdchk(tcc_pkg::IDX_START, 32'h0, "start reset");
        rdchk(tcc_pkg::IDX_CTRL, 32'h0, "control reset");
        rdchk(tcc_pkg::IDX_MODE, 32'h0, "mode reset");
        rdchk(tcc_pkg::IDX_STAT, 32'h0, "status reset");
        rdchk(tcc_pkg::IDX_CNT, 32'h0, "counter reset");
        rdchk(tcc_pkg::IDX_GRA, 32'hffff, "reg a reset");
        rdchk(tcc_pkg::IDX_MSTP, 32'h0, "stop reset");
        rd(IDX_VOID, q, tcc_pkg::RESP_SLVERR, tk);
        chk(q, 32'h0, "unmapped read data");
        wr(IDX_VOID, 32'h1, 4'hf, tcc_pkg::RESP_SLVERR);
        $display("test reset done");
    endtask
    // Undivided counting, one per cycle, and halt with the count held.
    task automatic t_run();
        wr(tcc_pkg::IDX_CTRL, 32'h0, 4'h1, OK);
        wr(tcc_pkg::IDX_MODE, 32'h0, 4'h1, OK);
        wr(tcc_pkg::IDX_START, 32'h1, 4'h1, OK);
        rd(tcc_pkg::IDX_CNT, a, OK, ta);
        repeat (10) @(posedge mclk);
        rd(tcc_pkg::IDX_CNT, b, OK, tb);
        chk(b - a, 32'(tb - ta), "count rate");
        wr(tcc_pkg::IDX_START, 32'h0, 4'h1, OK);
        rd(tcc_pkg::IDX_CNT, a, OK, ta);
        repeat (10) @(posedge mclk);
        rd(tcc_pkg::IDX_CNT, b, OK, tb);
        chk(b, a, "halted count");
        $display("test run done");
    endtask
    // Prescaled counting for each edge choice over a 64-cycle window.
    task automatic t_psc();
        logic [7:0] code [5] = '{8'h01, 8'h09, 8'h11, 8'h02, 8'h03};
        int dvs [5] = '{4, 4, 2, 16, 64};
        logic [31:0] lo, hi, q;
        for (int k = 0; k < 5; k++) begin
            wr(tcc_pkg::IDX_CTRL, {24'h0, code[k]}, 4'h1, OK);
            wr(tcc_pkg::IDX_START, 32'h1, 4'h1, OK);
            rd(tcc_pkg::IDX_CNT, a, OK, ta);
            repeat (61) @(posedge mclk);
            rd(tcc_pkg::IDX_CNT, b, OK, tb);
            wr(tcc_pkg::IDX_START, 32'h0, 4'h1, OK);
            lo = 32'((tb - ta) / dvs[k]);
            hi = 32'((tb - ta + dvs[k] - 1) / dvs[k]);
            q = b - a;
            chk({31'h0, q >= lo && q <= hi}, 32'h1, "psc rate");
        end
        wr(tcc_pkg::IDX_CTRL, 32'h0, 4'h1, OK);
        $display("test prescale done");
    endtask
    // Match flag A, its interrupt and the read-then-write-zero clear.
    task automatic t_flag();
        wr(tcc_pkg::IDX_CNT, 32'h0, 4'h3, OK);
        wr(tcc_pkg::IDX_GRA, 32'h20, 4'h3, OK);
        wr(tcc_pkg::IDX_START, 32'h1, 4'h1, OK);
        repeat (100) @(posedge mclk);
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(tcc_pkg::IDX_IEN, 32'h1, 4'h1, OK);
        repeat (3) @(posedge mclk);
        chk({31'h0, irq}, 32'h1, "irq on match");
        wr(tcc_pkg::IDX_STAT, 32'h0, 4'h1, OK);
        repeat (3) @(posedge mclk);
        chk({31'h0, irq}, 32'h1, "clear without read");
        rdchk(tcc_pkg::IDX_STAT, 32'h1, "flag set");
        wr(tcc_pkg::IDX_STAT, 32'h0, 4'h1, OK);
        rdchk(tcc_pkg::IDX_STAT, 32'h0, "flag cleared");
        repeat (3) @(posedge mclk);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        wr(tcc_pkg::IDX_START, 32'h0, 4'h1, OK);
        $display("test flag done");
    endtask
    // Clear source B with register B at 7 gives a period of eight.
    task automatic t_clrb();
        wr(tcc_pkg::IDX_CNT, 32'h0, 4'h3, OK);
        wr(tcc_pkg::IDX_CTRL, 32'h40, 4'h1, OK);
        wr(IDX_GRB, 32'h7, 4'h3, OK);
        wr(tcc_pkg::IDX_START, 32'h1, 4'h1, OK);
        rd(tcc_pkg::IDX_CNT, a, OK, ta);
        repeat (13) @(posedge mclk);
        rd(tcc_pkg::IDX_CNT, b, OK, tb);
        chk({31'h0, a < 32'd8}, 32'h1, "count bounded");
        chk(b, (a + 32'(tb - ta)) % 32'd8, "cleared count");
        wr(tcc_pkg::IDX_START, 32'h0, 4'h1, OK);
        wr(tcc_pkg::IDX_CTRL, 32'h0, 4'h1, OK);
        rdchk(tcc_pkg::IDX_STAT, 32'h2, "flag b set");
        wr(tcc_pkg::IDX_ICLR, 32'h2, 4'h1, OK);
        rdchk(tcc_pkg::IDX_STAT, 32'h0, "flag b cleared");
        $display("test clear b done");
    endtask
    // Module stop freezes counter and flag; release lets the match land.
    task automatic t_stop();
        wr(tcc_pkg::IDX_MSTP, 32'h2, 4'h3, OK);
        wr(tcc_pkg::IDX_CNT, 32'h10, 4'h3, OK);
        wr(tcc_pkg::IDX_GRA, 32'h12, 4'h3, OK);
        wr(tcc_pkg::IDX_START, 32'h1, 4'h1, OK);
        repeat (20) @(posedge mclk);
        rdchk(tcc_pkg::IDX_CNT, 32'h10, "stopped count");
        rdchk(tcc_pkg::IDX_STAT, 32'h0, "stopped flag");
        wr(tcc_pkg::IDX_MSTP, 32'h0, 4'h3, OK);
        repeat (20) @(posedge mclk);
        rdchk(tcc_pkg::IDX_STAT, 32'h1, "released flag");
        wr(tcc_pkg::IDX_START, 32'h0, 4'h1, OK);
        wr(tcc_pkg::IDX_STAT, 32'h0, 4'h1, OK);
        $display("test stop done");
    endtask
    // Buffer pairing of A with C and of B with D, each alone.
    task automatic t_pair();
        wr(tcc_pkg::IDX_MODE, 32'h10, 4'h1, OK);
        wr(tcc_pkg::IDX_GRA, 32'h30, 4'h3, OK);
        wr(IDX_GRC, 32'h55, 4'h3, OK);
        wr(IDX_GRB, 32'h40, 4'h3, OK);
        wr(IDX_GRD, 32'h66, 4'h3, OK);
        wr(tcc_pkg::IDX_CNT, 32'h0, 4'h3, OK);
        wr(tcc_pkg::IDX_START, 32'h1, 4'h1, OK);
        repeat (100) @(posedge mclk);
        wr(tcc_pkg::IDX_START, 32'h0, 4'h1, OK);
        rdchk(tcc_pkg::IDX_GRA, 32'h55, "a buffered");
        rdchk(IDX_GRB, 32'h40, "b alone");
        wr(tcc_pkg::IDX_MODE, 32'h20, 4'h1, OK);
        wr(IDX_GRC, 32'h77, 4'h3, OK);
        wr(tcc_pkg::IDX_CNT, 32'h0, 4'h3, OK);
        wr(tcc_pkg::IDX_START, 32'h1, 4'h1, OK);
        repeat (100) @(posedge mclk);
        wr(tcc_pkg::IDX_START, 32'h0, 4'h1, OK);
        rdchk(IDX_GRB, 32'h66, "b buffered");
        rdchk(tcc_pkg::IDX_GRA, 32'h55, "a alone");
        $display("test pair done");
    endtask
    // Watchdog well beyond the thousand or so cycles the tests need.
    initial begin
        #200000;
        err_count++;
        results();
    end
    // Reset for 20 cycles, then the scenarios in turn.
    initial begin
        rst = 1'b1;
        {awaddr, wdata, araddr, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_run();
        t_psc();
        t_flag();
        t_clrb();
        t_stop();
        t_pair();
        results();
    end
endmodule
`default_nettype wire
